// ==== adc_cal_pkg.sv ====
// Shared constants, field layouts and helpers of the calibration sequencer
package adc_cal_pkg;

    // Timing
    localparam int CLK_MHZ       = 200;
    localparam int MOD_CLK_DIV   = 32;
    localparam int DIV_W         = 5;
    localparam logic [DIV_W-1:0] MOD_DIV_LAST = DIV_W'(MOD_CLK_DIV - 1);

    // Calibration lengths in output periods
    localparam int PER_W = 6;
    localparam logic [PER_W-1:0] ZS_PER_CHOP   = 6'h16;
    localparam logic [PER_W-1:0] ZS_PER_NOCHOP = 6'h18;
    localparam logic [PER_W-1:0] FS_PER_CHOP   = 6'h2C;
    localparam logic [PER_W-1:0] FS_PER_NOCHOP = 6'h30;

    // Register byte offsets
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] ADDR_MODE    = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_FILTER  = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_OFFSET0 = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_OFFSET1 = 5'h0C;
    localparam logic [ADDR_W-1:0] ADDR_GAIN0   = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_GAIN1   = 5'h14;
    localparam logic [ADDR_W-1:0] ADDR_DATA    = 5'h18;
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 5'h1C;

    // Operating mode codes
    localparam logic [2:0] OP_IDLE   = 3'h0;
    localparam logic [2:0] OP_CONT   = 3'h1;
    localparam logic [2:0] OP_SINGLE = 3'h2;
    localparam logic [2:0] OP_ZS_INT = 3'h4;
    localparam logic [2:0] OP_FS_INT = 3'h5;

    localparam int COEF_W = 24;
    localparam int ACC_W  = 33;
    localparam int MODE_W = 9;
    localparam int FILT_W = 14;
    localparam int STAT_W = 3;

    typedef struct packed {
        logic       word24;
        logic       chan;
        logic       acExcitationEnable;
        logic       bipolar;
        logic       inputRangeSelHi;
        logic       inputRangeSelLo;
        logic [2:0] opMode;
    } mode_s;

    typedef struct packed {
        logic        chopEnable;
        logic        bypass;
        logic [11:0] decimationWord;
    } filter_s;

    typedef struct packed {
        logic pairPhase;
        logic calBusy;
        logic readyN;
    } status_s;

    localparam logic [MODE_W-1:0] MODE_RST   = 9'h100;
    localparam logic [FILT_W-1:0] FILTER_RST = 14'h2600;
    localparam logic [COEF_W-1:0] OFFSET_RST = 24'h000000;
    localparam logic [COEF_W-1:0] GAIN_RST   = 24'h800000;
    localparam logic [COEF_W-1:0] BIPOLAR_MID = 24'h800000;
    localparam logic [COEF_W-1:0] CODE_MAX    = 24'hFFFFFF;

    // Clamp a wide signed value into the signed 24-bit range
    function automatic logic [COEF_W-1:0] clamp24(input logic signed [ACC_W-1:0] v);
        if (v > 33'sh0007FFFFF) begin
            clamp24 = 24'h7FFFFF;
        end else if (v < -33'sh000800000) begin
            clamp24 = 24'h800000;
        end else begin
            clamp24 = v[COEF_W-1:0];
        end
    endfunction : clamp24

    function automatic logic isCalCode(input logic [2:0] op);
        isCalCode = (op == OP_ZS_INT) || (op == OP_FS_INT);
    endfunction : isCalCode

endpackage : adc_cal_pkg

// ==== adc_rate_timer.sv ====
// Modulator-rate and output-rate enable divider
`timescale 1ns/1ps
module adc_rate_timer
    import adc_cal_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [11:0] decimationWord,
    output logic             modTick,
    output logic             periodTick
);
    logic [DIV_W-1:0] divCnt_q;
    logic [11:0]      perCnt_q;
    logic [11:0]      perLast;

    assign perLast = (decimationWord == 12'h000) ? 12'h000 : decimationWord - 12'h001;
    assign modTick = (divCnt_q == MOD_DIV_LAST);
    assign periodTick = modTick && (perCnt_q >= perLast);

    always_ff @(posedge clk) begin
        if (reset) begin
            divCnt_q <= '0;
        end else begin
            divCnt_q <= modTick ? '0 : divCnt_q + DIV_W'(1);
        end
    end

    // One output period is a decimation word of modulator cycles
    always_ff @(posedge clk) begin
        if (reset) begin
            perCnt_q <= '0;
        end else if (periodTick) begin
            perCnt_q <= '0;
        end else if (modTick) begin
            perCnt_q <= perCnt_q + 12'h001;
        end
    end
endmodule : adc_rate_timer

// ==== adc_correction.sv ====
// Offset and gain correction of one filter output
`timescale 1ns/1ps
module adc_correction
    import adc_cal_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              inValid,
    input  wire logic [COEF_W-1:0] raw,
    input  wire logic [COEF_W-1:0] offset,
    input  wire logic [COEF_W-1:0] gain,
    input  wire logic              bipolar,
    input  wire logic              word24,
    output logic                   outValid,
    output logic [COEF_W-1:0]      result
);
    logic signed [ACC_W-1:0]   diff;
    logic signed [ACC_W+24:0]  prod;
    logic signed [ACC_W-1:0]   scaled;
    logic [COEF_W-1:0]         code;

    always_comb begin
        diff   = ACC_W'(signed'(raw)) - ACC_W'(signed'(offset));
        prod   = diff * signed'({1'b0, gain});
        scaled = prod[ACC_W+22:23];
        if (bipolar) begin
            code = clamp24(scaled) + BIPOLAR_MID;
        end else if (scaled[ACC_W-1]) begin
            code = '0;
        end else if (scaled[ACC_W-1:23] != '0) begin
            code = CODE_MAX;
        end else begin
            code = {scaled[22:0], 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            outValid <= 1'b0;
            result   <= '0;
        end else begin
            outValid <= inValid;
            if (inValid) begin
                result <= word24 ? code : {8'h00, code[23:8]};
            end
        end
    end
endmodule : adc_correction

// ==== adc_calibration_sequencer.sv ====
// Calibration sequencer, coefficient store and register slave of the converter
// Functional notes
// - Bypass bit set: outputs take only the first sinc3 stage.
// - Bypass with chopping off: each output is a complete result.
// - A calibration code written to the mode field starts calibration anytime.
// - Offset and gain coefficients are 24 bits, readable and writable.
// - Correction subtracts offset, then multiplies by gain.
// - Zero-scale fills channel offset; full-scale fills channel gain.
// - Arithmetic carries 33 bits; result is 16 or 24 bits.
// - Code 100 runs zero-scale with inputs shorted, range-set gain.
// - Code 101 runs full-scale from reference level, range-set gain.
// - Both internal calibrations use dc excitation regardless of ac bit.
// - Zero-scale lasts 22 periods chopped, 24 unchopped.
// - Full-scale lasts 44 periods chopped, 48 unchopped.
// - Finished calibration returns mode field to idle 000.
// - Ready (active low) high during calibration, low when done.
// - Ready may lag one modulator cycle; host ignores it meanwhile.
// - Bipolar zero input after zero-scale gives 800000 hex in 24-bit words, 8000 hex in 16-bit words.
// - Coefficients stay valid at every output rate.
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module adc_calibration_sequencer
    import adc_cal_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              stage1Valid,
    input  wire logic [COEF_W-1:0] stage1Data,
    input  wire logic              stage2Valid,
    input  wire logic [COEF_W-1:0] stage2Data,
    output logic                   readyN,
    output logic                   inputShort,
    output logic                   fullScaleRef,
    output logic                   acExcite,
    output logic                   stage2Enable,
    output logic [1:0]             pgaRange,
    output logic                   chopPhase
);
    typedef enum logic [1:0] {
        CAL_IDLE,
        CAL_ARM,
        CAL_ZERO,
        CAL_FULL
    } cal_e;

    cal_e              calState_q;
    logic [PER_W-1:0]  periodCnt_q;
    mode_s             mode_q;
    filter_s           filter_q;
    logic [COEF_W-1:0] offset_q [2];
    logic [COEF_W-1:0] gain_q [2];
    logic [COEF_W-1:0] data_q;
    logic [COEF_W-1:0] latestRaw_q;
    logic              wrPend_q;
    logic [ADDR_W-1:0] wrAddr_q;
    logic              pairPhase_q;

    logic              accept;
    logic              wrMode;
    logic              wrFilter;
    logic              rdData;
    logic [2:0]        newOp;
    logic              modTick;
    logic              periodTick;
    logic [PER_W-1:0]  zsLast;
    logic [PER_W-1:0]  fsLast;
    logic              calRunning;
    logic              zeroStore;
    logic              gainStore;
    logic              calDone;
    logic              sampleValid;
    logic [COEF_W-1:0] sampleData;
    logic              convActive;
    logic              corrValid;
    logic [COEF_W-1:0] corrResult;
    logic              singleDone;
    status_s           status;
    logic              chan;

    // Address decode of reads; writes compare wrAddr_q separately
    function automatic logic [31:0] readMux(input logic [ADDR_W-1:0] a);
        unique case (a)
            ADDR_MODE:    readMux = 32'(mode_q);
            ADDR_FILTER:  readMux = 32'(filter_q);
            ADDR_OFFSET0: readMux = {8'h00, offset_q[0]};
            ADDR_OFFSET1: readMux = {8'h00, offset_q[1]};
            ADDR_GAIN0:   readMux = {8'h00, gain_q[0]};
            ADDR_GAIN1:   readMux = {8'h00, gain_q[1]};
            ADDR_DATA:    readMux = {8'h00, data_q};
            ADDR_STATUS:  readMux = 32'(status);
            default:      readMux = 32'h00000000;
        endcase
    endfunction : readMux

    assign accept   = hsel && hready && htrans[1];
    assign wrMode   = wrPend_q && (wrAddr_q == ADDR_MODE);
    assign wrFilter = wrPend_q && (wrAddr_q == ADDR_FILTER);
    assign rdData   = accept && !hwrite && (haddr[ADDR_W-1:0] == ADDR_DATA);
    assign newOp    = hwdata[2:0];
    assign chan     = mode_q.chan;
    assign status   = '{pairPhase: pairPhase_q,
                        calBusy: (calState_q != CAL_IDLE),
                        readyN: readyN};

    adc_rate_timer u_timer (
        .clk            (clk),
        .reset          (reset),
        .decimationWord (filter_q.decimationWord),
        .modTick        (modTick),
        .periodTick     (periodTick)
    );

    // AHB-Lite address phase capture, zero wait states
    always_ff @(posedge clk) begin
        if (reset) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= '0;
        end else begin
            wrPend_q <= accept && hwrite;
            if (accept) begin
                wrAddr_q <= haddr[ADDR_W-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (accept && !hwrite) begin
                hrdata <= readMux(haddr[ADDR_W-1:0]);
            end
        end
    end

    // Mode field; a same-cycle host write wins over the hardware clear
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_q <= mode_s'(MODE_RST);
        end else if (wrMode) begin
            mode_q <= mode_s'(hwdata[MODE_W-1:0]);
        end else if (calDone || singleDone) begin
            mode_q.opMode <= OP_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            filter_q <= filter_s'(FILTER_RST);
        end else if (wrFilter) begin
            filter_q <= filter_s'(hwdata[FILT_W-1:0]);
        end
    end

    assign zsLast = (filter_q.chopEnable ? ZS_PER_CHOP : ZS_PER_NOCHOP) - PER_W'(1);
    assign fsLast = (filter_q.chopEnable ? FS_PER_CHOP : FS_PER_NOCHOP) - PER_W'(1);

    assign calRunning = (calState_q == CAL_ZERO) || (calState_q == CAL_FULL);
    assign zeroStore  = calRunning && periodTick && (periodCnt_q == zsLast);
    assign gainStore  = (calState_q == CAL_FULL) && periodTick && (periodCnt_q == fsLast);
    assign calDone    = ((calState_q == CAL_ZERO) && zeroStore) || gainStore;

    // Calibration sequence
    always_ff @(posedge clk) begin
        if (reset) begin
            calState_q  <= CAL_IDLE;
            periodCnt_q <= '0;
        end else if (wrMode) begin
            periodCnt_q <= '0;
            if (isCalCode(newOp)) begin
                calState_q <= CAL_ARM;
            end else begin
                calState_q <= CAL_IDLE;
            end
        end else begin
            unique case (calState_q)
                CAL_IDLE: begin
                    periodCnt_q <= '0;
                end
                CAL_ARM: begin
                    if (modTick) begin
                        if (mode_q.opMode == OP_ZS_INT) begin
                            calState_q <= CAL_ZERO;
                        end else begin
                            calState_q <= CAL_FULL;
                        end
                    end
                end
                CAL_ZERO, CAL_FULL: begin
                    if (calDone) begin
                        calState_q  <= CAL_IDLE;
                        periodCnt_q <= '0;
                    end else if (periodTick) begin
                        periodCnt_q <= periodCnt_q + PER_W'(1);
                    end
                end
            endcase
        end
    end

    assign sampleValid = filter_q.bypass ? stage1Valid : stage2Valid;
    assign sampleData  = filter_q.bypass ? stage1Data : stage2Data;

    always_ff @(posedge clk) begin
        if (reset) begin
            latestRaw_q <= '0;
        end else if (sampleValid) begin
            latestRaw_q <= sampleData;
        end
    end

    // Offset store; calibration wins over a same-cycle host write
    always_ff @(posedge clk) begin
        if (reset) begin
            offset_q[0] <= OFFSET_RST;
            offset_q[1] <= OFFSET_RST;
        end else if (zeroStore) begin
            offset_q[chan] <= latestRaw_q;
        end else if (wrPend_q && (wrAddr_q == ADDR_OFFSET0)) begin
            offset_q[0] <= hwdata[COEF_W-1:0];
        end else if (wrPend_q && (wrAddr_q == ADDR_OFFSET1)) begin
            offset_q[1] <= hwdata[COEF_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            gain_q[0] <= GAIN_RST;
            gain_q[1] <= GAIN_RST;
        end else if (gainStore) begin
            gain_q[chan] <= latestRaw_q - offset_q[chan];
        end else if (wrPend_q && (wrAddr_q == ADDR_GAIN0)) begin
            gain_q[0] <= hwdata[COEF_W-1:0];
        end else if (wrPend_q && (wrAddr_q == ADDR_GAIN1)) begin
            gain_q[1] <= hwdata[COEF_W-1:0];
        end
    end

    assign convActive = (calState_q == CAL_IDLE)
                     && ((mode_q.opMode == OP_CONT) || (mode_q.opMode == OP_SINGLE));

    adc_correction u_corr (
        .clk      (clk),
        .reset    (reset),
        .inValid  (sampleValid && convActive && !wrMode),
        .raw      (sampleData),
        .offset   (offset_q[chan]),
        .gain     (gain_q[chan]),
        .bipolar  (mode_q.bipolar),
        .word24   (mode_q.word24),
        .outValid (corrValid),
        .result   (corrResult)
    );

    assign singleDone = corrValid && (mode_q.opMode == OP_SINGLE) && convActive;

    always_ff @(posedge clk) begin
        if (reset) begin
            data_q <= '0;
        end else if (corrValid && convActive) begin
            data_q <= corrResult;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pairPhase_q <= 1'b0;
        end else if (!convActive || !filter_q.chopEnable) begin
            pairPhase_q <= 1'b0;
        end else if (corrValid) begin
            pairPhase_q <= !pairPhase_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            chopPhase <= 1'b0;
        end else begin
            chopPhase <= pairPhase_q;
        end
    end

    // Ready line, active low
    always_ff @(posedge clk) begin
        if (reset) begin
            readyN <= 1'b1;
        end else if ((calState_q == CAL_ARM) && modTick && !wrMode) begin
            readyN <= 1'b1;
        end else if (calDone && !wrMode) begin
            readyN <= 1'b0;
        end else if (corrValid && convActive) begin
            readyN <= 1'b0;
        end else if (rdData && convActive) begin
            readyN <= 1'b1;
        end
    end

    // Analog front-end controls
    always_ff @(posedge clk) begin
        if (reset) begin
            inputShort   <= 1'b0;
            fullScaleRef <= 1'b0;
        end else begin
            inputShort <= (calState_q == CAL_ZERO)
                       || ((calState_q == CAL_FULL) && (periodCnt_q <= zsLast));
            fullScaleRef <= (calState_q == CAL_FULL) && (periodCnt_q > zsLast);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            acExcite <= 1'b0;
        end else begin
            acExcite <= mode_q.acExcitationEnable && (calState_q == CAL_IDLE);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            stage2Enable <= 1'b1;
            pgaRange     <= 2'h0;
        end else begin
            stage2Enable <= !filter_q.bypass;
            pgaRange <= {mode_q.inputRangeSelHi, mode_q.inputRangeSelLo};
        end
    end

    // hsize is unused: only whole-word transfers reach this slave
endmodule : adc_calibration_sequencer

// ==== adc_calibration_sequencer_assertions.sv ====
// Port-level checker of the calibration sequencer
`timescale 1ns/1ps
module adc_calibration_sequencer_checker
    import adc_cal_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        readyN,
    input wire logic        inputShort,
    input wire logic        fullScaleRef,
    input wire logic        acExcite,
    input wire logic        stage2Enable,
    input wire logic [1:0]  pgaRange
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic        wrTake_q;
    logic        wrDone_q;
    logic [4:0]  addr_q, wrAddr_q;
    logic [31:0] wrData_q;
    // Tracks completed writes so outputs can be tied to register contents
    always_ff @(posedge clk) begin
        if (reset) begin
            wrTake_q <= 1'b0;
            wrDone_q <= 1'b0;
        end else begin
            wrTake_q <= hsel && hready && htrans[1] && hwrite;
            wrDone_q <= wrTake_q;
        end
    end
    always_ff @(posedge clk) begin
        if (hsel && hready && htrans[1]) begin
            addr_q <= haddr[4:0];
        end
        if (wrTake_q) begin
            wrAddr_q <= addr_q;
            wrData_q <= hwdata;
        end
    end
    wire modeWr = wrDone_q && wrAddr_q == ADDR_MODE;
    wire calWr  = modeWr && (wrData_q[2:0] == OP_ZS_INT || wrData_q[2:0] == OP_FS_INT);

    property p_bus_okay;
        hreadyout && !hresp;
    endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("bus slave not ready or not okay");
    property p_bypass;
        wrDone_q && wrAddr_q == ADDR_FILTER |-> ##[0:1] stage2Enable == !wrData_q[12];
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("second stage enable does not follow bypass bit");
    property p_range;
        modeWr |-> ##[0:1] pgaRange == wrData_q[4:3];
    endproperty
    a_range: assert property (p_range)
        else $error("gain range does not follow mode register");
    property p_cal_ready;
        calWr |-> ##[0:33] readyN;
    endproperty
    a_cal_ready: assert property (p_cal_ready)
        else $error("ready not high within one modulator cycle of cal");
    property p_short;
        calWr |-> ##[1:35] (inputShort && !fullScaleRef);
    endproperty
    a_short: assert property (p_short)
        else $error("inputs not shorted at cal start");
    property p_fs_ref;
        fullScaleRef |-> !inputShort && (readyN || $past(readyN));
    endproperty
    a_fs_ref: assert property (p_fs_ref)
        else $error("full-scale reference outside full-scale phase");
    property p_dc;
        inputShort || fullScaleRef |-> !acExcite;
    endproperty
    a_dc: assert property (p_dc)
        else $error("ac excitation during calibration");
    property p_start;
        $rose(inputShort) |-> readyN;
    endproperty
    a_start: assert property (p_start)
        else $error("ready low while calibrating");
    property p_end;
        $fell(fullScaleRef) |-> ##[0:1] !readyN;
    endproperty
    a_end: assert property (p_end)
        else $error("ready not low at end of full-scale cal");
endmodule : adc_calibration_sequencer_checker

bind adc_calibration_sequencer adc_calibration_sequencer_checker chk (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .readyN(readyN), .inputShort(inputShort),
    .fullScaleRef(fullScaleRef), .acExcite(acExcite), .stage2Enable(stage2Enable),
    .pgaRange(pgaRange)
);

// ==== adc_filter_source.sv ====
// Front-end model: filter samples of the shorted, reference or applied input
`timescale 1ns/1ps
module adc_filter_source
    import adc_cal_pkg::*;
#(
    parameter logic [COEF_W-1:0] ZERO_CODE = 24'h012345,
    parameter logic [COEF_W-1:0] FULL_CODE = 24'h3ABCDE
)
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              inputShort,
    input  wire logic              fullScaleRef,
    input  wire logic [COEF_W-1:0] inCode,
    output logic                   stage1Valid,
    output logic [COEF_W-1:0]      stage1Data,
    output logic                   stage2Valid,
    output logic [COEF_W-1:0]      stage2Data
);
    logic [2:0]        div_q;
    logic [COEF_W-1:0] code;
    assign code = inputShort ? ZERO_CODE : (fullScaleRef ? FULL_CODE : inCode);
    always_ff @(posedge clk) begin
        div_q       <= reset ? 3'h0 : div_q + 3'h1;
        stage1Valid <= !reset && div_q == 3'h7;
        stage2Valid <= !reset && div_q == 3'h7;
        // Data is garbage outside the valid cycle
        stage1Data  <= (div_q == 3'h7) ? code : ~code;
        stage2Data  <= (div_q == 3'h7) ? code : ~code;
    end
endmodule : adc_filter_source

// ==== adc_calibration_sequencer_bench.sv ====
// Self-checking bench of the calibration sequencer
`timescale 1ns/1ps
module adc_calibration_sequencer_bench import adc_cal_pkg::*;;
    localparam logic [23:0] ZC = 24'h012345;
    localparam logic [23:0] FC = 24'h3ABCDE;
    logic clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0, pgaRange;
    logic [2:0] hsize = 3'h2;
    logic [23:0] inCode = 24'h0, s1d, s2d;
    logic hreadyout, hresp, s1v, s2v, readyN, inputShort, fullScaleRef;
    logic acExcite, stage2Enable, chopPhase;
    int mismatches = 0, num_checks = 0, cyc = 0;
    always #2.5 clk = ~clk;
    adc_calibration_sequencer dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .stage1Valid(s1v),
        .stage1Data(s1d), .stage2Valid(s2v), .stage2Data(s2d), .readyN(readyN),
        .inputShort(inputShort), .fullScaleRef(fullScaleRef), .acExcite(acExcite),
        .stage2Enable(stage2Enable), .pgaRange(pgaRange), .chopPhase(chopPhase));
    adc_filter_source #(.ZERO_CODE(ZC), .FULL_CODE(FC)) src (.clk(clk), .reset(reset),
        .inputShort(inputShort), .fullScaleRef(fullScaleRef), .inCode(inCode),
        .stage1Valid(s1v), .stage1Data(s1d), .stage2Valid(s2v), .stage2Data(s2d));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {27'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus
    task automatic t_reset_values();
        logic [31:0] r;
        bus(1'b0, ADDR_MODE, 32'h0, r);
        check(r, 32'h00000100, "mode reset");
        bus(1'b0, ADDR_FILTER, 32'h0, r);
        check(r, 32'h00002600, "filter reset");
        bus(1'b0, ADDR_GAIN0, 32'h0, r);
        check(r, 32'h00800000, "gain reset");
    endtask : t_reset_values
    task automatic t_coef_access();
        logic [31:0] r;
        bus(1'b1, ADDR_OFFSET0, 32'hFFFFFFFF, r);
        bus(1'b1, ADDR_GAIN1, 32'h00654321, r);
        bus(1'b0, ADDR_OFFSET0, 32'h0, r);
        check(r, 32'h00FFFFFF, "offset width");
        bus(1'b0, ADDR_GAIN1, 32'h0, r);
        check(r, 32'h00654321, "gain write");
    endtask : t_coef_access
    task automatic t_calibrate(input logic chop, input logic fs, input logic ch,
                               input logic early);
        logic [31:0] m, r;
        int n = 0, per;
        per = fs ? (chop ? 44 : 48) : (chop ? 22 : 24);
        m = {23'h0, 1'b1, ch, 2'b11, 2'b11, 1'b1, 1'b0, fs};
        bus(1'b1, ADDR_FILTER, {18'h0, chop, 13'h0001}, r);
        if (early) begin
            bus(1'b1, ADDR_MODE, m & 32'hFFFFFFF8 | 32'h4, r);
            repeat (100) @(posedge clk);
        end
        bus(1'b1, ADDR_MODE, m, r);
        while (readyN !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        while (readyN !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        check(32'(n >= per * 32 && n <= per * 32 + 36), 32'h1, "cal length");
        bus(1'b0, ADDR_MODE, 32'h0, r);
        check(r, m & 32'hFFFFFFF8, "mode after cal");
        bus(1'b0, ch ? ADDR_OFFSET1 : ADDR_OFFSET0, 32'h0, r);
        check(r, {8'h0, ZC}, "offset coef");
        if (fs) begin
            bus(1'b0, ch ? ADDR_GAIN1 : ADDR_GAIN0, 32'h0, r);
            check(r, {8'h0, FC - ZC}, "gain coef");
        end
    endtask : t_calibrate
    task automatic t_convert(input logic chop);
        logic [31:0] r, p;
        int n;
        inCode <= ZC;
        bus(1'b1, ADDR_FILTER, {18'h0, chop, 1'b1, 12'h001}, r);
        bus(1'b1, ADDR_MODE, {23'h0, !chop, 8'h21}, r);
        for (int k = 0; k < 4; k++) begin
            bus(1'b0, ADDR_DATA, 32'h0, r);
            @(posedge clk);
            n = 0;
            while (readyN !== 1'b0 && n < 200) begin
                @(posedge clk);
                n++;
            end
            check(32'(n < 200), 32'h1, "single output ready");
            if (k > 1 || !chop) check(32'(chopPhase), 32'(chop & !p[0]), "pairs");
            p = 32'(chopPhase);
        end
        bus(1'b0, ADDR_DATA, 32'h0, r);
        check(r, chop ? 32'h00008000 : 32'h00800000, "bipolar zero");
        check(32'(stage2Enable), 32'h0, "second stage off");
    endtask : t_convert
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset_values();
        t_coef_access();
        t_calibrate(1'b1, 1'b1, 1'b1, 1'b1);
        t_calibrate(1'b1, 1'b0, 1'b1, 1'b0);
        t_calibrate(1'b0, 1'b1, 1'b0, 1'b0);
        t_calibrate(1'b0, 1'b0, 1'b0, 1'b0);
        t_convert(1'b0);
        t_convert(1'b1);
        close_out();
    end
endmodule : adc_calibration_sequencer_bench
